// [rtl/lpgc_pkg.sv]
// shared constants and types for the led panel global configuration block
package lpgc_pkg;
   // register address codes
   localparam logic [3:0] ADR_DRV_ADDR = 4'h0;
   localparam logic [3:0] ADR_PIX_SCALE = 4'h1;
   localparam logic [3:0] ADR_GLOBAL_LO = 4'h8;
   localparam logic [3:0] ADR_PANEL_CFG = 4'hD;
   localparam logic [3:0] ADR_DRV_COUNT = 4'hE;
   localparam logic [3:0] ADR_DRV_ROWS = 4'hF;
   // panel configuration fields
   localparam int B_RUN = 0;
   localparam int B_NEGATE = 1;
   localparam int B_PLANE_LO = 2;
   localparam int B_PLANE_HI = 3;
   localparam int B_RIPPLE = 4;
   localparam int B_FLIP = 5;
   localparam int B_COLOUR = 6;
   localparam int B_DEPTH = 7;
   // reset values
   localparam logic [7:0] RST_PANEL_CFG = 8'h30;
   localparam logic [7:0] RST_DRV_COUNT = 8'hFF;
   localparam logic [7:0] RST_DRV_ROWS = 8'hFF;
   localparam logic [1:0] RST_PIX_SCALE = 2'h0;
   // serial frame layout
   localparam int FRAME_BITS = 16;
   localparam int B_FRM_RD = 15;
   localparam logic [4:0] RD_TURN = 5'h08;
   // timing
   localparam int CLK_PS = 10_000;
   localparam int RIPPLE_PS = 953_700;
   localparam int RIPPLE_CYC = RIPPLE_PS / CLK_PS;
   localparam logic [3:0] ALLOC_HALF = 4'h7;
   localparam logic [3:0] ALLOC_BITS = 4'h8;
   localparam logic [3:0] ROWS = 4'h8;
   localparam int BYTES_PER_PLANE = 16;

   typedef enum logic [2:0] {
      ST_RX = 3'b001,
      ST_TX = 3'b010,
      ST_RUN = 3'b100
   } lpgc_alloc_e;

   typedef struct packed {
      logic [7:0] row_o;
      logic row_oe;
      logic [15:0] col_o;
      logic col_oe;
   } lpgc_drive_s;

   typedef struct packed {
      logic [7:0] drv_addr;
      logic [7:0] panel_row;
      logic [7:0] panel_col;
      logic [15:0] mem_base;
      logic busy;
   } lpgc_alloc_s;
endpackage : lpgc_pkg

// [rtl/lpgc_top.sv]
// led panel global configuration: serial register access, address chain, mux control
//
// Behaviour
// [RULE_01] reset registers, address zero, 256 drivers, mono
// [RULE_02] after reset, chain pass assigns driver addresses
// [RULE_03] allocation done leaves device in shutdown
// [RULE_04] panel configuration register at code 0x0D
// [RULE_05] run bit zero shuts down, one runs
// [RULE_06] shutdown floats rows, columns; stops multiplexing
// [RULE_07] shutdown keeps configuration register contents
// [RULE_08] negate bit inverts which memory level lights
// [RULE_09] plane bits report active plane, read only; reads return raw plane_code, not active_plane
// [RULE_10] depth select folds codes 10/11 to planes 0/1
// [RULE_11] ripple sync staggers drivers by quarter timebase
// [RULE_12] mux flip reverses timing on odd addresses
// [RULE_13] colour bit selects RGY; absent variant reads zero
// [RULE_14] depth bit selects two planes; absent variant zero
// [RULE_15] host programs configuration before displaying images
// [RULE_16] host writes driver count minus one
// [RULE_17] host writes drivers per row minus one
// [RULE_18] engine recomputes memory allocation from configuration
// [RULE_19] pixel scale acts only in two-bit mode
// [RULE_20] driver count at 0x0E resets to all ones
// [RULE_21] row length at 0x0F resets to all ones
// [RULE_22] global reads answered only by driver zero
// [RULE_23] ripple delay equals own address times step
`timescale 1ns/1ps
module lpgc_top
   import lpgc_pkg::*;
#(
   parameter bit HAS_RGY = 1'b1,
   parameter bit HAS_DEPTH = 1'b1,
   parameter int ROW_CYC = 2048,
   parameter int FRAME_CYC = 65536
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // host serial interface
   input wire logic csn,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // local chain bus
   input wire logic chain_head,
   input wire logic chain_clk_i,
   input wire logic chain_dat_i,
   input wire logic sync_i,
   output logic chain_clk_o,
   output logic chain_dat_o,
   output logic sync_o,
   // display memory side
   input wire logic [1:0] plane_code,
   input wire logic [15:0] pixel_bits,
   output logic [2:0] scan_row,
   output logic [1:0] active_plane,
   output logic [1:0] pixel_scale,
   output lpgc_alloc_s alloc,
   // panel drive
   output lpgc_drive_s drive
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] csn_s, sclk_s, din_s, cclk_s, cdat_s, sync_s, head_s;
      logic sclk_p, cclk_p, sync_p;
      logic [4:0] nbits;
      logic [15:0] sh_in;
      logic [7:0] sh_out;
      logic rd_ok;
      logic [7:0] cfg, count, rows;
      logic [1:0] scale;
      lpgc_alloc_e st;
      logic started;
      logic [7:0] addr;
      logic [3:0] bit_n, div;
      logic [7:0] tx;
      logic cclk_o;
      logic [16:0] frame_cnt, wait_cnt, row_cnt;
      logic waiting, scanning;
      logic [2:0] row;
      logic [7:0] rem, prow;
      logic busy;
      logic syn_o;
   } lpgc_state_s;

   lpgc_state_s s_q, s_d;
   logic sclk_rise, sclk_fall, cclk_rise, sync_ev, frame_end, mux_on, odd_flip;
   logic [7:0] rd_data, wr_data;
   logic [3:0] rd_reg;

   assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_p;
   assign sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_p;
   assign cclk_rise = s_q.cclk_s[1] & ~s_q.cclk_p;
   assign frame_end = (s_q.frame_cnt == 17'(FRAME_CYC - 1));
   assign sync_ev = s_q.head_s[1] ? frame_end : (s_q.sync_s[1] & ~s_q.sync_p);
   assign mux_on = s_q.cfg[B_RUN] & (s_q.st == ST_RUN); // RULE_05 RULE_06
   assign odd_flip = s_q.cfg[B_FLIP] & s_q.addr[0]; // RULE_12
   assign rd_reg = s_q.sh_in[3:0];

   // write data with read-only and absent-variant bits masked
   always_comb begin
      wr_data = s_q.sh_in[7:0];
      wr_data[B_PLANE_HI:B_PLANE_LO] = 2'h0; // RULE_09
      wr_data[B_COLOUR] = s_q.sh_in[B_COLOUR] & HAS_RGY; // RULE_13
      wr_data[B_DEPTH] = s_q.sh_in[B_DEPTH] & HAS_DEPTH; // RULE_14
   end

   always_comb begin
      unique case (rd_reg)
         ADR_DRV_ADDR: rd_data = s_q.addr;
         ADR_PIX_SCALE: rd_data = {6'h00, s_q.scale};
         ADR_PANEL_CFG: rd_data = {s_q.cfg[7:4], plane_code, s_q.cfg[1:0]}; // RULE_09
         ADR_DRV_COUNT: rd_data = s_q.count;
         ADR_DRV_ROWS: rd_data = s_q.rows;
         default: rd_data = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.csn_s = {s_q.csn_s[0], csn};
      s_d.sclk_s = {s_q.sclk_s[0], sclk};
      s_d.din_s = {s_q.din_s[0], din};
      s_d.cclk_s = {s_q.cclk_s[0], chain_clk_i};
      s_d.cdat_s = {s_q.cdat_s[0], chain_dat_i};
      s_d.sync_s = {s_q.sync_s[0], sync_i};
      s_d.head_s = {s_q.head_s[0], chain_head};
      s_d.sclk_p = s_q.sclk_s[1];
      s_d.cclk_p = s_q.cclk_s[1];
      s_d.sync_p = s_q.sync_s[1];

      // allocation engine first, so a restart requested in the same cycle wins
      if (s_q.busy) begin
         if (s_q.rem > s_q.rows) begin
            s_d.rem = s_q.rem - s_q.rows - 8'h01; // RULE_18
            s_d.prow = s_q.prow + 8'h01;
         end else begin
            s_d.busy = 1'b0;
         end
      end

      // host frame: 16 bits msb first; a read turns dout on after 8 bits
      if (s_q.csn_s[1]) begin
         if (s_q.nbits == 5'(FRAME_BITS) && !s_q.sh_in[B_FRM_RD] && s_q.st == ST_RUN) begin
            unique case (s_q.sh_in[11:8])
               ADR_PIX_SCALE: s_d.scale = s_q.sh_in[1:0];
               ADR_PANEL_CFG: s_d.cfg = wr_data; // RULE_04
               ADR_DRV_COUNT: s_d.count = s_q.sh_in[7:0]; // RULE_16
               ADR_DRV_ROWS: s_d.rows = s_q.sh_in[7:0]; // RULE_17
               default: s_d.cfg = s_q.cfg;
            endcase
            if (s_q.sh_in[11:8] >= ADR_PANEL_CFG) begin
               s_d.busy = 1'b1; // RULE_18
               s_d.rem = s_q.addr;
               s_d.prow = 8'h00;
            end
         end
         s_d.nbits = 5'h00;
         s_d.rd_ok = 1'b0;
      end else begin
         if (sclk_rise && s_q.nbits != 5'(FRAME_BITS)) begin
            s_d.sh_in = {s_q.sh_in[14:0], s_q.din_s[1]};
            s_d.nbits = s_q.nbits + 5'h01;
         end
         if (sclk_rise && s_q.nbits == RD_TURN - 5'h01) begin
            s_d.sh_out = 8'h00;
         end
         if (s_q.nbits == RD_TURN && s_q.sh_in[7] && !s_q.rd_ok && sclk_fall) begin
            s_d.rd_ok = (s_q.addr == 8'h00) || (rd_reg < ADR_GLOBAL_LO); // RULE_22
            s_d.sh_out = rd_data;
         end else if (sclk_fall && s_q.rd_ok) begin
            s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
         end
      end

      // address chain pass after reset
      unique case (s_q.st)
         ST_RX: begin
            if (!s_q.started) begin
               s_d.started = 1'b1;
            end else if (s_q.head_s[1]) begin
               s_d.addr = 8'h00;
               s_d.tx = 8'h01;
               s_d.st = ST_TX;
            end else if (cclk_rise) begin
               s_d.addr = {s_q.addr[6:0], s_q.cdat_s[1]}; // RULE_02
               s_d.bit_n = s_q.bit_n + 4'h1;
               if (s_q.bit_n == ALLOC_BITS - 4'h1) begin
                  s_d.tx = {s_q.addr[6:0], s_q.cdat_s[1]} + 8'h01;
                  s_d.bit_n = 4'h0;
                  s_d.st = ST_TX;
               end
            end
         end
         ST_TX: begin
            s_d.div = s_q.div + 4'h1;
            if (s_q.div == ALLOC_HALF) begin
               s_d.div = 4'h0;
               s_d.cclk_o = ~s_q.cclk_o;
               if (s_q.cclk_o) begin
                  s_d.tx = {s_q.tx[6:0], 1'b0};
                  s_d.bit_n = s_q.bit_n + 4'h1;
                  if (s_q.bit_n == ALLOC_BITS - 4'h1) begin
                     s_d.st = ST_RUN;
                     s_d.cfg[B_RUN] = 1'b0; // RULE_03
                     s_d.busy = 1'b1;
                     s_d.rem = s_q.addr;
                     s_d.prow = 8'h00;
                  end
               end
            end
         end
         ST_RUN: s_d.st = ST_RUN;
      endcase

      // multiplex sequencer, halted in shutdown
      s_d.syn_o = 1'b0;
      if (s_q.head_s[1]) begin
         s_d.frame_cnt = frame_end ? 17'h00000 : s_q.frame_cnt + 17'h00001;
         s_d.syn_o = frame_end;
      end
      if (!mux_on) begin
         s_d.waiting = 1'b0; // RULE_06
         s_d.scanning = 1'b0;
      end else if (sync_ev) begin
         s_d.waiting = 1'b1;
         s_d.scanning = 1'b0;
         s_d.wait_cnt = s_q.cfg[B_RIPPLE] ? 17'(s_q.addr * RIPPLE_CYC) : 17'h00000; // RULE_11 RULE_23
      end else if (s_q.waiting) begin
         if (s_q.wait_cnt == 17'h00000) begin
            s_d.waiting = 1'b0;
            s_d.scanning = 1'b1;
            s_d.row = 3'h0;
            s_d.row_cnt = 17'h00000;
         end else begin
            s_d.wait_cnt = s_q.wait_cnt - 17'h00001;
         end
      end else if (s_q.scanning) begin
         s_d.row_cnt = s_q.row_cnt + 17'h00001;
         if (s_q.row_cnt == 17'(ROW_CYC - 1)) begin
            s_d.row_cnt = 17'h00000;
            s_d.row = s_q.row + 3'h1;
            s_d.scanning = (s_q.row != 3'(ROWS - 4'h1));
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_q <= '0; // RULE_01
         s_q.cfg <= RST_PANEL_CFG;
         s_q.count <= RST_DRV_COUNT; // RULE_20
         s_q.rows <= RST_DRV_ROWS; // RULE_21
         s_q.scale <= RST_PIX_SCALE;
         s_q.st <= ST_RX;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic [2:0] phys_row;
   assign phys_row = odd_flip ? ~s_q.row : s_q.row; // RULE_12
   assign dout = s_q.sh_out[7];
   assign dout_oe = s_q.rd_ok & ~s_q.csn_s[1];
   assign chain_clk_o = s_q.cclk_o;
   assign chain_dat_o = s_q.tx[7];
   assign sync_o = s_q.syn_o;
   assign scan_row = phys_row;
   assign active_plane = s_q.cfg[B_DEPTH] ? {1'b0, plane_code[0]} : plane_code; // RULE_10
   assign pixel_scale = s_q.cfg[B_DEPTH] ? s_q.scale : 2'h3; // RULE_19
   assign alloc.drv_addr = s_q.addr;
   assign alloc.panel_row = s_q.prow;
   assign alloc.panel_col = s_q.rem;
   assign alloc.mem_base = 16'(s_q.addr * (BYTES_PER_PLANE << s_q.cfg[B_DEPTH]));
   assign alloc.busy = s_q.busy;
   // drive outputs only float; register contents stay untouched
   assign drive.row_oe = mux_on; // RULE_06 RULE_07
   assign drive.col_oe = mux_on;
   assign drive.row_o = s_q.scanning ? (8'h01 << phys_row) : 8'h00;
   assign drive.col_o = s_q.scanning ? (pixel_bits ^ {16{s_q.cfg[B_NEGATE]}}) : 16'h0000; // RULE_08

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_float;
      @(posedge mclk) disable iff (!rstn) !s_q.cfg[B_RUN] |-> !drive.row_oe && !drive.col_oe;
   endproperty
   a_float: assert property (p_float) else $error("drivers on in shutdown"); // RULE_06
   property p_shut_after_alloc;
      @(posedge mclk) disable iff (!rstn)
         (s_q.st == ST_TX) ##1 (s_q.st == ST_RUN) |-> !s_q.cfg[B_RUN];
   endproperty
   a_shut_after_alloc: assert property (p_shut_after_alloc) else $error("run after alloc"); // RULE_03
   property p_plane_ro;
      @(posedge mclk) disable iff (!rstn) s_q.cfg[B_PLANE_HI:B_PLANE_LO] == 2'h0;
   endproperty
   a_plane_ro: assert property (p_plane_ro) else $error("plane bits stored"); // RULE_09
   property p_rgy;
      @(posedge mclk) disable iff (!rstn) !HAS_RGY |-> !s_q.cfg[B_COLOUR];
   endproperty
   a_rgy: assert property (p_rgy) else $error("colour bit set on mono variant"); // RULE_13
   property p_depth;
      @(posedge mclk) disable iff (!rstn) !HAS_DEPTH |-> !s_q.cfg[B_DEPTH];
   endproperty
   a_depth: assert property (p_depth) else $error("depth bit set on variant"); // RULE_14
   property p_neg;
      @(posedge mclk) disable iff (!rstn)
         s_q.scanning |-> drive.col_o == (pixel_bits ^ {16{s_q.cfg[B_NEGATE]}});
   endproperty
   a_neg: assert property (p_neg) else $error("column polarity wrong"); // RULE_08
   property p_global_rd;
      @(posedge mclk) disable iff (!rstn)
         $rose(s_q.rd_ok) && s_q.addr != 8'h00 |-> rd_reg < ADR_GLOBAL_LO;
   endproperty
   a_global_rd: assert property (p_global_rd) else $error("non-zero driver answered"); // RULE_22
   property p_ripple;
      @(posedge mclk) disable iff (!rstn)
         mux_on && sync_ev && !s_q.cfg[B_RIPPLE] |=> s_q.waiting ##1 s_q.scanning;
   endproperty
   a_ripple: assert property (p_ripple) else $error("unrippled start late"); // RULE_11
   property p_halt;
      @(posedge mclk) disable iff (!rstn) !mux_on |=> !s_q.scanning && !s_q.waiting;
   endproperty
   a_halt: assert property (p_halt) else $error("mux ran in shutdown"); // RULE_06
   property p_scale;
      @(posedge mclk) disable iff (!rstn) !s_q.cfg[B_DEPTH] |-> pixel_scale == 2'h3;
   endproperty
   a_scale: assert property (p_scale) else $error("scale active in one-bit mode"); // RULE_19
   c_alloc: cover property (@(posedge mclk) disable iff (!rstn) s_q.st == ST_RUN);
   c_scan: cover property (@(posedge mclk) disable iff (!rstn) s_q.scanning);
   c_read: cover property (@(posedge mclk) disable iff (!rstn) dout_oe);
endmodule : lpgc_top

// [testbench/lpgc_host.sv]
// host microprocessor model on the 4-wire serial register port
`timescale 1ns/1ps
module lpgc_host (
   // clock
   input wire logic mclk,
   // serial port
   output logic csn,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   logic oe_seen;

   initial begin
      csn = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
      oe_seen = 1'b0;
   end

   // ------------------------------
   // one 16-bit frame, 160 ns sclk
   // ------------------------------
   task automatic half_bit();
      repeat (8) @(posedge mclk);
      #1;
   endtask : half_bit

   task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
      rd = 8'h00;
      oe_seen = 1'b0;
      @(posedge mclk);
      #1;
      csn = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din = frame[i];
         half_bit();
         // read data settles half a bit after each falling edge
         if (i < 8) begin
            rd = {rd[6:0], dout};
            oe_seen = oe_seen | dout_oe;
         end
         sclk = 1'b1;
         half_bit();
         sclk = 1'b0;
      end
      half_bit();
      csn = 1'b1;
      // released line must not keep its last level
      din = ~frame[0];
      repeat (8) @(posedge mclk);
   endtask : xfer
endmodule : lpgc_host

// [testbench/lpgc_top_tb.sv]
// self-checking bench for the panel configuration block
`timescale 1ns/1ps
module lpgc_top_tb
   import lpgc_pkg::*;
;
   logic mclk, rstn, csn, sclk, din, dout, dout_oe;
   logic chain_head, chain_clk_i, chain_dat_i, sync_i, chain_clk_o, chain_dat_o, sync_o;
   logic [1:0] plane_code;
   logic [15:0] pixel_bits;
   logic [2:0] scan_row;
   logic [1:0] active_plane;
   logic [1:0] pixel_scale;
   lpgc_alloc_s alloc;
   lpgc_drive_s drive;
   logic [7:0] rd;
   int errors = 0;
   int checked = 0;

   lpgc_top #(.ROW_CYC(16), .FRAME_CYC(2000)) DUT (
      .mclk(mclk), .rstn(rstn), .csn(csn), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe(dout_oe), .chain_head(chain_head), .chain_clk_i(chain_clk_i),
      .chain_dat_i(chain_dat_i), .sync_i(sync_i), .chain_clk_o(chain_clk_o),
      .chain_dat_o(chain_dat_o), .sync_o(sync_o), .plane_code(plane_code),
      .pixel_bits(pixel_bits), .scan_row(scan_row), .active_plane(active_plane),
      .pixel_scale(pixel_scale), .alloc(alloc), .drive(drive)
   );

   lpgc_host HOST (
      .mclk(mclk), .csn(csn), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe)
   );

   // ------------------------------
   // helpers
   // ------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] code, input logic [7:0] data);
      HOST.xfer({4'h0, code, data}, rd);
      tick(10);
   endtask : wr

   task automatic rdr(input logic [3:0] code);
      HOST.xfer({4'h8, code, 8'h00}, rd);
   endtask : rdr

   task automatic reset_dut(input logic head);
      rstn = 1'b0;
      chain_head = head;
      chain_clk_i = 1'b0;
      chain_dat_i = 1'b0;
      tick(12);
      rstn = 1'b1;
   endtask : reset_dut

   // upstream word in, downstream word out, then the end-of-pass busy pulse
   task automatic chain(input logic head, input logic [7:0] up, output logic [7:0] word);
      logic prev;
      int cnt;
      word = 8'h00;
      prev = 1'b0;
      cnt = 0;
      fork
         begin
            // the head strap has no upstream neighbour
            for (int i = 7; i >= 0 && !head; i--) begin
               chain_dat_i = up[i];
               tick(8);
               chain_clk_i = 1'b1;
               tick(8);
               chain_clk_i = 1'b0;
            end
            chain_dat_i = 1'b1;
         end
         for (int n = 0; n < 4000 && cnt < 8; n++) begin
            tick(1);
            if (chain_clk_o === 1'b1 && prev === 1'b0) begin
               word = {word[6:0], chain_dat_o};
               cnt++;
            end
            prev = chain_clk_o;
         end
      join
      for (int n = 0; n < 4000 && alloc.busy !== 1'b1; n++) tick(1);
      chk("pass busy", 8'h01, {7'h00, alloc.busy});
      for (int n = 0; n < 4000 && alloc.busy !== 1'b0; n++) tick(1);
   endtask : chain

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_alloc();
      logic [7:0] word;
      chain(1'b0, 8'h00, word);
      chk("next address", 8'h01, word);
      chk("own address", 8'h00, alloc.drv_addr);
      chk("oe after pass", 8'h00, {6'h00, drive.row_oe, drive.col_oe});
      rdr(ADR_PANEL_CFG);
      chk("cfg reset", RST_PANEL_CFG, rd);
      rdr(ADR_DRV_COUNT);
      chk("count reset", 8'hFF, rd);
      rdr(ADR_DRV_ROWS);
      chk("rows reset", 8'hFF, rd);
      rdr(ADR_PIX_SCALE);
      chk("scale reset", 8'h00, {6'h00, rd[1:0]});
   endtask : t_alloc

   task automatic t_count();
      wr(ADR_DRV_COUNT, 8'h17);
      wr(ADR_DRV_ROWS, 8'h05);
      rdr(ADR_DRV_COUNT);
      chk("count", 8'h17, rd);
      rdr(ADR_DRV_ROWS);
      chk("rows", 8'h05, rd);
   endtask : t_count

   task automatic t_shut();
      logic [2:0] row;
      wr(ADR_PANEL_CFG, 8'h01);
      chk("oe running", 8'h03, {6'h00, drive.row_oe, drive.col_oe});
      plane_code = 2'b01;
      // plane bits written as 10 must be dropped
      wr(ADR_PANEL_CFG, 8'hFA);
      chk("oe shutdown", 8'h00, {6'h00, drive.row_oe, drive.col_oe});
      row = scan_row;
      tick(200);
      chk("scan halted", {5'h00, row}, {5'h00, scan_row});
      rdr(ADR_PANEL_CFG);
      chk("cfg kept", 8'hF6, rd);
      chk("answered", 8'h01, {7'h00, HOST.oe_seen});
   endtask : t_shut

   task automatic t_modes();
      logic [1:0] exp;
      wr(ADR_PIX_SCALE, 8'h02);
      for (int d = 0; d < 2; d++) begin
         wr(ADR_PANEL_CFG, {d[0], 7'h31});
         chk("scale", d == 1 ? 8'h02 : 8'h03, {6'h00, pixel_scale});
         for (int c = 0; c < 4; c++) begin
            plane_code = c[1:0];
            tick(3);
            exp = (d == 1 && c > 1) ? c[1:0] - 2'h2 : c[1:0];
            chk("plane", {6'h00, exp}, {6'h00, active_plane});
         end
      end
   endtask : t_modes

   // odd, non-zero address: refused global reads, flip, ripple, allocation
   task automatic t_odd();
      logic [7:0] word;
      int l0;
      int l1;
      reset_dut(1'b0);
      chain(1'b0, 8'h05, word);
      chk("next address odd", 8'h06, word);
      rdr(ADR_DRV_ADDR);
      chk("odd address", 8'h05, rd);
      chk("local answered", 1, HOST.oe_seen);
      rdr(ADR_DRV_COUNT);
      chk("global silent", 0, HOST.oe_seen);
      wr(ADR_DRV_ROWS, 8'h01);
      chk("panel row", 2, alloc.panel_row);
      chk("panel col", 1, alloc.panel_col);
      chk("mem base", 5 * BYTES_PER_PLANE, alloc.mem_base);
      wr(ADR_PANEL_CFG, 8'h21);
      @(posedge sync_i);
      for (l0 = 0; l0 < 3000 && drive.row_o === 8'h00; l0++) tick(1);
      chk("flipped row", 8'h80, drive.row_o);
      chk("plain columns", 16'hA5C3, drive.col_o);
      wr(ADR_PANEL_CFG, 8'h33);
      @(posedge sync_i);
      for (l1 = 0; l1 < 3000 && drive.row_o === 8'h00; l1++) tick(1);
      chk("negated columns", 16'h5A3C, drive.col_o);
      chk("ripple delay", 5 * RIPPLE_CYC, l1 - l0);
   endtask : t_odd

   // head of the chain makes its own sync
   task automatic t_head();
      logic [7:0] word;
      reset_dut(1'b1);
      chain(1'b1, 8'h00, word);
      chk("head next address", 8'h01, word);
      wr(ADR_PANEL_CFG, 8'h01);
      for (int n = 0; n < 2500 && sync_o !== 1'b1; n++) tick(1);
      chk("head sync", 1, sync_o);
      tick(2);
      chk("head scan", 8'h01, drive.row_o);
      chk("head columns", 16'hA5C3, drive.col_o);
   endtask : t_head

   // ------------------------------
   // clock, reset, sync, watchdog
   // ------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      sync_i = 1'b0;
      forever begin
         tick(2000);
         sync_i = 1'b1;
         tick(1);
         sync_i = 1'b0;
      end
   end

   initial begin
      #300us;
      errors++;
      results();
   end

   initial begin
      plane_code = 2'b00;
      pixel_bits = 16'hA5C3;
      reset_dut(1'b0);
      t_alloc();
      t_count();
      t_shut();
      t_modes();
      t_odd();
      t_head();
      results();
   end
endmodule : lpgc_top_tb
